// *** pkg/ieee488_listen_pkg.sv ***
// constants, state codes and carriers for the listener acceptor handshake
// assumes a single 10 MHz core clock; all bus pins already synchronous to it
package ieee488_listen_pkg;

   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 100;
   // longest time from ATN falling to NDAC pulled low (rounds down)
   localparam int unsigned ATN_RESP_NS    = 200;
   localparam int unsigned ATN_RESP_CYC   = (ATN_RESP_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                            (ATN_RESP_NS / CLK_PERIOD_NS);
   // least time from NRFD pulled low to NDAC released (rounds up)
   localparam int unsigned NDAC_DELAY_NS  = 30;
   localparam int unsigned NDAC_DELAY_CYC = ((NDAC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                            ((NDAC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int unsigned DLY_W          = 4;

   // ----------------------------------------------------------------------
   // command bytes and field positions
   // ----------------------------------------------------------------------
   localparam int unsigned ADDR_W         = 5;
   localparam int unsigned GROUP_LSB      = 5;
   localparam logic [2:0]  LISTEN_GROUP   = 3'h1;
   localparam logic [7:0]  CMD_UNLISTEN   = 8'h3F;
   localparam logic        LISTEN_RST     = 1'b0;

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      HS_IDLE  = 3'h0,
      HS_READY = 3'h1,
      HS_TAKE  = 3'h3,
      HS_DONE  = 3'h2,
      HS_HOLD  = 3'h6
   } hs_state_t;

   // bus levels as seen on the connector, all active low
   typedef struct packed {
      logic       atn_n;
      logic       dav_n;
      logic       ifc_n;
      logic       nrfd_n;
      logic       ndac_n;
      logic [7:0] dio_n;
   } gpib_in_t;

   // bus data lines carry negative logic
   function automatic logic [7:0] bus_byte(input logic [7:0] dio_n);
      return ~dio_n;
   endfunction

endpackage

// *** core/listen_addr_decode.sv ***
// listen address tracker: collects command bytes while ATN is low
// assumes one strobe per accepted command byte from the acceptor handshake
`timescale 1ns/1ps
module listen_addr_decode
   import ieee488_listen_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   input  wire logic              i_ifc_n,
   input  wire logic              i_atn_n,
   input  wire logic              i_cmd_valid,
   input  wire logic [7:0]        i_cmd,
   input  wire logic [ADDR_W-1:0] i_my_addr,
   output      logic              o_listen
);

   typedef struct packed {
      logic pend;
      logic listen;
   } dec_state_t;

   dec_state_t q;
   dec_state_t d;

   always_comb begin
      d = q;
      if (!i_ifc_n) begin
         d.pend   = LISTEN_RST;
         d.listen = LISTEN_RST;
      end else if (i_atn_n) begin
         // the outcome of a whole addressing sequence lands only now
         d.listen = q.pend;
      end else if (i_cmd_valid) begin
         if (i_cmd == {LISTEN_GROUP, i_my_addr}) begin
            d.pend = 1'b1;
         end else if (i_cmd == CMD_UNLISTEN) begin
            d.pend = 1'b0;
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_listen = q.listen;

endmodule // listen_addr_decode

// *** core/byte_buffer2.sv ***
// two-entry buffer between the bus capture and the peripheral
// output word and valid are held in flip-flops, ready on the input is
// combinational from the fill state
`timescale 1ns/1ps
module byte_buffer2 #(
   parameter int unsigned W = 8
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   input  wire logic         i_in_valid,
   input  wire logic [W-1:0] i_in_data,
   output      logic         o_in_ready,
   output      logic         o_out_valid,
   output      logic [W-1:0] o_out_data,
   input  wire logic         i_out_ready
);

   typedef struct packed {
      logic [W-1:0] head;
      logic [W-1:0] tail;
      logic         head_v;
      logic         tail_v;
   } buf_state_t;

   buf_state_t q;
   buf_state_t d;

   always_comb begin
      d = q;
      if (q.head_v && i_out_ready) begin
         if (q.tail_v) begin
            d.head   = q.tail;
            d.tail_v = 1'b0;
         end else begin
            d.head_v = 1'b0;
         end
      end
      if (i_in_valid && !q.tail_v) begin
         if (!d.head_v) begin
            d.head   = i_in_data;
            d.head_v = 1'b1;
         end else begin
            d.tail   = i_in_data;
            d.tail_v = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_in_ready  = !q.tail_v;
   assign o_out_valid = q.head_v;
   assign o_out_data  = q.head;

endmodule // byte_buffer2

// *** core/ieee488_listen_handshake.sv ***
// listener acceptor handshake: drives NRFD/NDAC against ATN, DAV and IFC
// assumes bus inputs synchronous to i_core_clk; open-drain outputs are
// resolved by the surroundings from the output enables
//
// Behaviour
// - ATN high and not addressed: bus idle, every line released.
// - ATN low: handshake every byte and decode each as address.
// - own address seen: keep decoding, act only once ATN rises.
// - after ATN falls pull NDAC low in time, NRFD per readiness.
// - ATN low: no bus byte ever reaches the peripheral.
// - ATN high and addressed: capture each byte, deliver as data.
// - peripheral busy or full buffer stalls the bus, no byte lost.
// - IFC low: go idle, release handshake lines.
// - unlisten byte (63) under ATN leaves listen state.
// - idle: NRFD and NDAC both released high.
// - listen flag set only by own primary listen address.
// - drivers enabled only when ATN low or listen flag set.
// - on ATN fall release NRFD while pulling NDAC low.
// - DAV low: pull NRFD low, then release NDAC shortly after.
`timescale 1ns/1ps
module ieee488_listen_handshake
   import ieee488_listen_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   input  wire gpib_in_t          i_bus,
   input  wire logic [ADDR_W-1:0] i_my_addr,
   output      logic              o_nrfd_o,
   output      logic              o_nrfd_oe,
   output      logic              o_ndac_o,
   output      logic              o_ndac_oe,
   output      logic              o_drv_en,
   output      logic              o_listen,
   output      logic [7:0]        o_data,
   output      logic              o_data_valid,
   input  wire logic              i_data_ready,
   input  wire logic              i_busy
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      hs_state_t        st;
      logic [DLY_W-1:0] dly;
      logic             drv;
      logic             nrfd_oe;
      logic             ndac_oe;
   } hs_regs_t;

   hs_regs_t q;
   hs_regs_t d;

   logic       listen;
   logic       addr_mode;
   logic       data_mode;
   logic       active;
   logic       cmd_stb;
   logic       push;
   logic       buf_ready;
   logic       buf_valid;
   logic [7:0] buf_data;

   assign addr_mode = !i_bus.atn_n;
   assign data_mode = i_bus.atn_n && listen;
   assign active    = addr_mode || listen;

   // ----------------------------------------------------------------------
   // acceptor sequence
   // ----------------------------------------------------------------------
   always_comb begin
      d       = q;
      cmd_stb = 1'b0;
      push    = 1'b0;
      if (!i_bus.ifc_n) begin
         d.st = HS_IDLE;
      end else if (!active) begin
         d.st = HS_IDLE;
      end else begin
         case (q.st)
            HS_IDLE: begin
               // addresses can always be taken; data waits for the peripheral
               d.st = addr_mode ? HS_READY : HS_HOLD;
            end
            HS_READY: begin
               if (!i_bus.dav_n) begin
                  if (addr_mode) begin
                     cmd_stb = 1'b1;
                     d.st    = HS_TAKE;
                     d.dly   = DLY_W'(NDAC_DELAY_CYC - 1);
                  end else if (buf_ready) begin
                     push    = 1'b1;
                     d.st    = HS_TAKE;
                     d.dly   = DLY_W'(NDAC_DELAY_CYC - 1);
                  end
                  // a full buffer keeps NDAC low until room appears
               end else if (data_mode && (i_busy || !buf_ready)) begin
                  d.st = HS_HOLD;
               end
            end
            HS_TAKE: begin
               if (q.dly == '0) begin
                  d.st = HS_DONE;
               end else begin
                  d.dly = q.dly - 1'b1;
               end
            end
            HS_DONE: begin
               if (i_bus.dav_n) begin
                  d.st = HS_HOLD;
               end
            end
            HS_HOLD: begin
               if (i_bus.dav_n && (addr_mode || (!i_busy && buf_ready))) begin
                  d.st = HS_READY;
               end
            end
            default: begin
               d.st = HS_IDLE;
            end
         endcase
      end

      // ---------------------------------------------------------------------
      // line drive, registered alongside the state it belongs to
      // ---------------------------------------------------------------------
      d.drv     = i_bus.ifc_n && active;
      d.nrfd_oe = d.drv && (d.st == HS_TAKE || d.st == HS_DONE || d.st == HS_HOLD);
      d.ndac_oe = d.drv && (d.st == HS_READY || d.st == HS_TAKE || d.st == HS_HOLD);
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '{st: HS_IDLE, dly: '0, drv: 1'b0, nrfd_oe: 1'b0, ndac_oe: 1'b0};
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // address tracking and peripheral path
   // ----------------------------------------------------------------------
   listen_addr_decode u_decode (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .i_ifc_n     (i_bus.ifc_n),
      .i_atn_n     (i_bus.atn_n),
      .i_cmd_valid (cmd_stb),
      .i_cmd       (bus_byte(i_bus.dio_n)),
      .i_my_addr   (i_my_addr),
      .o_listen    (listen)
   );

   // only data-mode pushes enter, so commands never reach the peripheral
   byte_buffer2 #(
      .W (8)
   ) u_buf (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .i_in_valid  (push),
      .i_in_data   (bus_byte(i_bus.dio_n)),
      .o_in_ready  (buf_ready),
      .o_out_valid (buf_valid),
      .o_out_data  (buf_data),
      .i_out_ready (i_data_ready)
   );

   // open-drain: the driven level is always low, enable means pulling
   assign o_nrfd_o     = 1'b0;
   assign o_ndac_o     = 1'b0;
   assign o_nrfd_oe    = q.nrfd_oe;
   assign o_ndac_oe    = q.ndac_oe;
   assign o_drv_en     = q.drv;
   assign o_listen     = listen;
   assign o_data       = buf_data;
   assign o_data_valid = buf_valid;

endmodule // ieee488_listen_handshake

// *** sim/ieee488_listen_handshake_monitor.sv ***
// port assertions for the listener acceptor handshake
// assumes it is bound into the top module, one clock domain
`timescale 1ns/1ps
module ieee488_listen_handshake_monitor
   import ieee488_listen_pkg::*;
(
   input wire logic       i_core_clk,
   input wire logic       i_rst,
   input wire gpib_in_t   i_bus,
   input wire logic       o_nrfd_oe,
   input wire logic       o_ndac_oe,
   input wire logic       o_drv_en,
   input wire logic       o_listen,
   input wire logic [7:0] o_data,
   input wire logic       o_data_valid,
   input wire logic       i_data_ready,
   input wire logic       i_busy
);
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   property p_ifc;
      !i_bus.ifc_n |=> !(o_nrfd_oe | o_ndac_oe | o_drv_en | o_listen);
   endproperty
   a_ifc: assert property (p_ifc) else $error("clear left lines driven");
   property p_idle;
      !o_drv_en |-> !o_nrfd_oe && !o_ndac_oe;
   endproperty
   a_idle: assert property (p_idle) else $error("line driven while disabled");
   property p_atn;
      $fell(i_bus.atn_n) && i_bus.ifc_n && !o_drv_en |=> o_ndac_oe && !o_nrfd_oe && o_drv_en;
   endproperty
   a_atn: assert property (p_atn) else $error("slow attention response");
   // only the address phase: in data mode a full buffer may hold the byte
   property p_dav;
      !i_bus.atn_n && i_bus.ifc_n && o_ndac_oe && !o_nrfd_oe && !i_bus.dav_n
         |=> o_nrfd_oe ##1 !o_ndac_oe;
   endproperty
   a_dav: assert property (p_dav) else $error("address byte not accepted");
   property p_busy;
      o_listen && i_bus.atn_n && i_bus.ifc_n && i_busy && o_nrfd_oe && o_ndac_oe |=> o_nrfd_oe;
   endproperty
   a_busy: assert property (p_busy) else $error("ready released while busy");
   property p_hold;
      i_bus.ifc_n && o_data_valid && !i_data_ready |=> o_data_valid && $stable(o_data);
   endproperty
   a_hold: assert property (p_hold) else $error("byte dropped before taken");
   property p_nodata;
      $rose(o_data_valid) |-> $past(i_bus.atn_n, 2);
   endproperty
   a_nodata: assert property (p_nodata) else $error("byte delivered under attention");
   property p_lrise;
      $rose(o_listen) |-> $past(i_bus.atn_n);
   endproperty
   a_lrise: assert property (p_lrise) else $error("listen set under attention");
   c_listen: cover property ($rose(o_listen));
   c_take: cover property (o_data_valid && i_data_ready);
   c_unl: cover property ($fell(o_listen) && i_bus.ifc_n);
endmodule // ieee488_listen_handshake_monitor

bind ieee488_listen_handshake ieee488_listen_handshake_monitor i_mon (
   .i_core_clk,
   .i_rst,
   .i_bus,
   .o_nrfd_oe,
   .o_ndac_oe,
   .o_drv_en,
   .o_listen,
   .o_data,
   .o_data_valid,
   .i_data_ready,
   .i_busy
);

// *** sim/gpib_ctrl_model.sv ***
// bus controller model: drives attention, clear, data valid and data
// assumes the device is the only acceptor; free lines float high
`timescale 1ns/1ps
module gpib_ctrl_model
   import ieee488_listen_pkg::*;
(
   input  wire logic     i_core_clk,
   input  wire logic     i_nrfd_oe,
   input  wire logic     i_ndac_oe,
   output wire gpib_in_t o_bus
);
   logic       atn_n = 1'h1;
   logic       dav_n = 1'h1;
   logic       ifc_n = 1'h1;
   logic [7:0] dio_n = 8'hFF;
   assign o_bus = {atn_n, dav_n, ifc_n, ~i_nrfd_oe, ~i_ndac_oe, dio_n};
   // ----------
   // tasks
   // ----------
   task automatic set(input logic a, input logic c);
      @(negedge i_core_clk);
      atn_n = a;
      ifc_n = c;
   endtask
   // slow holds data valid that many extra cycles after acceptance
   task automatic send(input logic [7:0] b, input int slow, output bit ok);
      int n;
      ok = 1'b0;
      for (n = 0; n < 50 && i_nrfd_oe; n++) @(negedge i_core_clk);
      if (i_nrfd_oe) return;
      dio_n = ~b;
      @(negedge i_core_clk);
      dav_n = 1'h0;
      for (n = 0; n < 200 && i_ndac_oe; n++) @(negedge i_core_clk);
      if (i_ndac_oe) return;
      repeat (slow) @(negedge i_core_clk);
      dav_n = 1'h1;
      dio_n = 8'hFF;
      ok = 1'b1;
   endtask
endmodule // gpib_ctrl_model

// *** sim/ieee488_listen_handshake_bench.sv ***
// self-checking bench for the listener acceptor handshake
// assumes the controller model on the bus side, bench as peripheral
`timescale 1ns/1ps
module ieee488_listen_handshake_bench;
   import ieee488_listen_pkg::*;
   localparam logic [4:0] MY = 5'h05;
   logic       i_core_clk;
   logic       i_rst;
   logic       i_data_ready;
   logic       i_busy;
   wire        gpib_in_t i_bus;
   logic       o_nrfd_o;
   logic       o_ndac_o;
   logic       o_nrfd_oe;
   logic       o_ndac_oe;
   logic       o_drv_en;
   logic       o_listen;
   logic [7:0] o_data;
   logic       o_data_valid;
   int         err_total;
   int         checks;
   // drv_en, nrfd_oe, ndac_oe, listen
   wire logic [3:0] st = {o_drv_en, o_nrfd_oe, o_ndac_oe, o_listen};

   ieee488_listen_handshake i_ieee488_listen_handshake (
      .i_core_clk,
      .i_rst,
      .i_bus,
      .i_my_addr(MY),
      .o_nrfd_o,
      .o_nrfd_oe,
      .o_ndac_o,
      .o_ndac_oe,
      .o_drv_en,
      .o_listen,
      .o_data,
      .o_data_valid,
      .i_data_ready,
      .i_busy
   );
   gpib_ctrl_model i_gpib_ctrl_model (
      .i_core_clk,
      .i_nrfd_oe(o_nrfd_oe),
      .i_ndac_oe(o_ndac_oe),
      .o_bus(i_bus)
   );
   // ----------
   // helpers
   // ----------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic finish_test;
      if (err_total == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   task automatic snd(input logic [7:0] b, input int slow);
      bit ok;
      i_gpib_ctrl_model.send(b, slow, ok);
      chk("handshake", 8'h01, {7'h0, ok});
      if (!ok) finish_test;
   endtask
   task automatic take(input logic [7:0] e);
      int n;
      for (n = 0; n < 60 && o_data_valid !== 1'b1; n++) tick(1);
      chk("valid", 8'h01, {7'h0, o_data_valid});
      if (o_data_valid !== 1'b1) finish_test;
      chk("data", e, o_data);
      i_data_ready = 1'h1;
      tick(1);
      i_data_ready = 1'h0;
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_addr;
      i_gpib_ctrl_model.set(1'h0, 1'h1);
      tick(1);
      chk("atn", 8'h0A, st);
      snd(8'h2A, 0);
      snd({3'h1, MY}, 2);
      snd(8'h45, 0);
      tick(2);
      chk("early", 8'h0A, st);
      chk("cut off", 8'h00, o_data_valid);
      i_gpib_ctrl_model.set(1'h1, 1'h1);
      tick(2);
      chk("listen", 8'h01, o_listen);
   endtask
   task automatic t_data;
      fork
         begin
            snd(8'h11, 0);
            snd(8'h22, 0);
            snd(8'h33, 0);
         end
         begin
            tick(40);
            // both entries full: nrfd stays pulled until the peripheral takes one
            chk("stall", 8'h0F, st);
            take(8'h11);
            take(8'h22);
            take(8'h33);
         end
      join
   endtask
   task automatic t_busy;
      snd(8'h44, 0);
      // busy rises while the byte is still being closed on the bus
      i_busy = 1'h1;
      tick(8);
      chk("busy", 8'h0F, st);
      i_busy = 1'h0;
      tick(2);
      chk("free", 8'h0B, st);
      take(8'h44);
   endtask
   task automatic t_unl;
      i_gpib_ctrl_model.set(1'h0, 1'h1);
      tick(1);
      snd(8'h3F, 0);
      snd(8'h2A, 0);
      tick(2);
      chk("deferred", 8'h0B, st);
      chk("cut off", 8'h00, o_data_valid);
      i_gpib_ctrl_model.set(1'h1, 1'h1);
      tick(3);
      chk("unlisten", 8'h00, st);
   endtask
   // clear arrives while an own address is still pending
   task automatic t_ifc;
      i_gpib_ctrl_model.set(1'h0, 1'h1);
      tick(1);
      snd({3'h1, MY}, 0);
      i_gpib_ctrl_model.set(1'h0, 1'h0);
      tick(1);
      chk("clear", 8'h00, st);
      i_gpib_ctrl_model.set(1'h1, 1'h1);
      tick(3);
      chk("pending", 8'h00, st);
   endtask

   initial begin
      i_core_clk = 1'h0;
      forever #50 i_core_clk = ~i_core_clk;
   end
   initial begin
      i_rst = 1'h1;
      i_data_ready = 1'h0;
      i_busy = 1'h0;
      err_total = 0;
      checks = 0;
      repeat (20) @(posedge i_core_clk);
      tick(1);
      i_rst = 1'h0;
      tick(2);
      chk("idle", 8'h00, st);
      chk("pull level", 8'h00, {6'h0, o_nrfd_o, o_ndac_o});
      t_addr;
      t_data;
      t_busy;
      t_unl;
      t_ifc;
      finish_test;
   end
endmodule // ieee488_listen_handshake_bench
